//--- rtl/atf_pkg.sv
// Purpose: shared constants for the task file register block
// Assumes: 100 MHz clk, host pins asynchronous to clk
// Notes:   offsets are the three low host address bits
package atf_pkg;

   localparam int unsigned ATF_AW = 3;
   localparam int unsigned ATF_DW = 16;
   localparam int unsigned ATF_RW = 8;

   // register offsets
   localparam logic [ATF_AW-1:0] ATF_OFF_DATA   = 3'h0;
   localparam logic [ATF_AW-1:0] ATF_OFF_FAULT  = 3'h1;
   localparam logic [ATF_AW-1:0] ATF_OFF_PRECMP = 3'h1;
   localparam logic [ATF_AW-1:0] ATF_OFF_SCOUNT = 3'h2;
   localparam logic [ATF_AW-1:0] ATF_OFF_SINDEX = 3'h3;
   localparam logic [ATF_AW-1:0] ATF_OFF_TRK_LO = 3'h4;
   localparam logic [ATF_AW-1:0] ATF_OFF_TRK_HI = 3'h5;
   localparam logic [ATF_AW-1:0] ATF_OFF_DRVHD  = 3'h6;
   localparam logic [ATF_AW-1:0] ATF_OFF_COND   = 3'h7;
   localparam logic [ATF_AW-1:0] ATF_OFF_OPCODE = 3'h7;

   // reset values
   localparam logic [ATF_RW-1:0] ATF_RST_BYTE = 8'h00;
   localparam logic [ATF_DW-1:0] ATF_RST_WORD = 16'h0000;

   // operation code upper nibble
   localparam logic [3:0] ATF_NIB_RESTORE = 4'h1;
   localparam logic [3:0] ATF_NIB_SEEK    = 4'h7;
   localparam logic [3:0] ATF_NIB_READ    = 4'h2;
   localparam logic [3:0] ATF_NIB_WRITE   = 4'h3;
   localparam logic [3:0] ATF_NIB_FORMAT  = 4'h5;
   localparam logic [3:0] ATF_NIB_VERIFY  = 4'h4;
   localparam logic [3:0] ATF_NIB_DIAGSET = 4'h9;

   // operation code bit positions
   localparam int unsigned ATF_BIT_SELPAR = 0;
   localparam int unsigned ATF_BIT_RETRY  = 0;
   localparam int unsigned ATF_BIT_LONG   = 1;
   localparam int unsigned ATF_BIT_DMA    = 3;
   localparam int unsigned ATF_RATE_MSB   = 3;
   localparam int unsigned ATF_NIB_MSB    = 7;
   localparam int unsigned ATF_NIB_LSB    = 4;

   // decoded operation, one-hot
   typedef enum logic [8:0] {
      ATF_OP_NONE    = 9'h001,
      ATF_OP_RESTORE = 9'h002,
      ATF_OP_SEEK    = 9'h004,
      ATF_OP_READ    = 9'h008,
      ATF_OP_WRITE   = 9'h010,
      ATF_OP_FORMAT  = 9'h020,
      ATF_OP_VERIFY  = 9'h040,
      ATF_OP_DIAG    = 9'h080,
      ATF_OP_SETPAR  = 9'h100
   } atf_op_e;

endpackage

//--- rtl/atf_task_file.sv
// Purpose: drive-side task file registers facing the host
// Assumes: host holds address and write data stable around its strobes
// Notes:   strobes and select pass a three-stage filter before use
`timescale 1ns/1ps

// Contract
// [RULE1] registers answer host reads and writes only while task file select is low
// [RULE2] data port is sixteen bits wide, every other register eight bits
// [RULE3] register layout follows the standard disk task file offsets and meanings
// [RULE4] restore and seek take the low four command bits as step rate
// [RULE5] read, write, format, verify command bit three requests sixteen-bit dma
// [RULE6] read or write sector bit one appends error-correction bytes after data
// [RULE7] read, write or verify bit zero inhibits automatic retries
// [RULE8] command upper nibble selects operation; bit zero splits diagnose from set parameters
module atf_task_file (
   input  wire logic                         clk,
   input  wire logic                         srst,
   // host pins
   input  wire logic                         task_file_select_n,
   input  wire logic                         host_rd_n,
   input  wire logic                         host_wr_n,
   input  wire logic [atf_pkg::ATF_AW-1:0]   host_addr,
   input  wire logic [atf_pkg::ATF_DW-1:0]   host_data_i,
   output logic      [atf_pkg::ATF_DW-1:0]   host_data_o,
   output logic                              host_data_oe,
   // drive side: condition inputs
   input  wire logic                         busy,
   input  wire logic                         ready,
   input  wire logic                         write_fault_flag,
   input  wire logic                         seek_done_flag,
   input  wire logic                         data_request,
   input  wire logic                         corrected_data_flag,
   input  wire logic                         index_pulse,
   input  wire logic                         error_summary,
   // drive side: fault inputs
   input  wire logic                         bad_block_flag,
   input  wire logic                         crc_error_flag,
   input  wire logic                         header_not_found_flag,
   input  wire logic                         command_aborted_flag,
   input  wire logic                         track_zero_missing_flag,
   input  wire logic                         address_mark_missing_flag,
   // drive side: sector data
   input  wire logic [atf_pkg::ATF_DW-1:0]   sector_rd_word,
   output logic                              sector_rd_take,
   output logic      [atf_pkg::ATF_DW-1:0]   sector_wr_word,
   output logic                              sector_wr_put,
   // drive side: register contents
   output logic      [atf_pkg::ATF_RW-1:0]   precomp_cyl,
   output logic      [atf_pkg::ATF_RW-1:0]   sector_count,
   output logic      [atf_pkg::ATF_RW-1:0]   sector_index,
   output logic      [atf_pkg::ATF_RW-1:0]   track_low,
   output logic      [atf_pkg::ATF_RW-1:0]   track_high,
   output logic      [atf_pkg::ATF_RW-1:0]   drive_head,
   // drive side: decoded command
   output logic                              cmd_start,
   output atf_pkg::atf_op_e                  cmd_op,
   output logic      [3:0]                   step_rate,
   output logic                              use_dma,
   output logic                              long_xfer,
   output logic                              retry_inhibit
);
   import atf_pkg::*;

   ////////////////////////////////////////////////////////////////////////////
   // pin filters: three stages, a change counts when stages two and three agree

   localparam int unsigned NPIN = 3;
   logic [NPIN-1:0] pin_raw;
   logic [NPIN-1:0] pin_s1_r;
   logic [NPIN-1:0] pin_s2_r;
   logic [NPIN-1:0] pin_s3_r;
   logic [NPIN-1:0] pin_f_r;

   assign pin_raw = {task_file_select_n, host_rd_n, host_wr_n};

   genvar gi;
   generate
      for (gi = 0; gi < NPIN; gi++) begin : g_pin
         always_ff @(posedge clk) begin
            if (srst) begin
               pin_s1_r[gi] <= 1'b1;
               pin_s2_r[gi] <= 1'b1;
               pin_s3_r[gi] <= 1'b1;
               pin_f_r[gi]  <= 1'b1;
            end else begin
               pin_s1_r[gi] <= pin_raw[gi];
               pin_s2_r[gi] <= pin_s1_r[gi];
               pin_s3_r[gi] <= pin_s2_r[gi];
               if (pin_s2_r[gi] == pin_s3_r[gi]) begin
                  pin_f_r[gi] <= pin_s3_r[gi];
               end
            end
         end
      end
   endgenerate

   wire sel_n_f = pin_f_r[2];
   wire rd_n_f  = pin_f_r[1];
   wire wr_n_f  = pin_f_r[0];

   // filtered strobe levels one cycle back, for edge detection
   logic rd_n_d_r;
   logic wr_n_d_r;

   // address and data have settled long before a strobe passes the filter,
   // so a single capture stage suffices here
   logic [ATF_AW-1:0] addr_r;
   logic [ATF_DW-1:0] wdata_r;

   always_ff @(posedge clk) begin
      if (srst) begin
         rd_n_d_r <= 1'b1;
         wr_n_d_r <= 1'b1;
         addr_r   <= '0;
         wdata_r  <= ATF_RST_WORD;
      end else begin
         rd_n_d_r <= rd_n_f;
         wr_n_d_r <= wr_n_f;
         addr_r   <= host_addr;
         wdata_r  <= host_data_i;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // access decode

   wire selected  = ~sel_n_f;                             // RULE1
   wire rd_active = selected & ~rd_n_f;                   // RULE1
   wire rd_start  = rd_active & rd_n_d_r;
   wire wr_start  = selected & ~wr_n_f & wr_n_d_r;        // RULE1

   wire wr_data   = wr_start & (addr_r == ATF_OFF_DATA);  // RULE3
   wire wr_precmp = wr_start & (addr_r == ATF_OFF_PRECMP);
   wire wr_scount = wr_start & (addr_r == ATF_OFF_SCOUNT);
   wire wr_sindex = wr_start & (addr_r == ATF_OFF_SINDEX);
   wire wr_trk_lo = wr_start & (addr_r == ATF_OFF_TRK_LO);
   wire wr_trk_hi = wr_start & (addr_r == ATF_OFF_TRK_HI);
   wire wr_drvhd  = wr_start & (addr_r == ATF_OFF_DRVHD);
   wire wr_opcode = wr_start & (addr_r == ATF_OFF_OPCODE);
   wire rd_data   = rd_start & (addr_r == ATF_OFF_DATA);

   wire [ATF_RW-1:0] wbyte = wdata_r[ATF_RW-1:0];        // RULE2

   ////////////////////////////////////////////////////////////////////////////
   // read path

   wire [ATF_RW-1:0] fault_byte = {bad_block_flag, crc_error_flag, 1'b0, header_not_found_flag,
                                   1'b0, command_aborted_flag, track_zero_missing_flag,
                                   address_mark_missing_flag};                     // RULE3
   wire [ATF_RW-1:0] cond_byte  = {busy, ready, write_fault_flag, seek_done_flag,
                                   data_request, corrected_data_flag, index_pulse,
                                   error_summary};                                 // RULE3

   logic [ATF_RW-1:0] rd_byte;
   always_comb begin
      case (addr_r)
         ATF_OFF_FAULT:  rd_byte = fault_byte;
         ATF_OFF_SCOUNT: rd_byte = sector_count;
         ATF_OFF_SINDEX: rd_byte = sector_index;
         ATF_OFF_TRK_LO: rd_byte = track_low;
         ATF_OFF_TRK_HI: rd_byte = track_high;
         ATF_OFF_DRVHD:  rd_byte = drive_head;
         ATF_OFF_COND:   rd_byte = cond_byte;
         default:        rd_byte = ATF_RST_BYTE;
      endcase
   end

   // byte registers read with the upper lane at zero
   wire [ATF_DW-1:0] rd_word = (addr_r == ATF_OFF_DATA) ? sector_rd_word
                                                        : {ATF_RST_BYTE, rd_byte};  // RULE2

   always_ff @(posedge clk) begin
      if (srst) begin
         host_data_o    <= ATF_RST_WORD;
         host_data_oe   <= 1'b0;
         sector_rd_take <= 1'b0;
      end else begin
         host_data_o    <= rd_word;
         host_data_oe   <= rd_active;                     // RULE1
         sector_rd_take <= rd_data;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // writable registers

   always_ff @(posedge clk) begin
      if (srst) begin
         precomp_cyl    <= ATF_RST_BYTE;
         sector_count   <= ATF_RST_BYTE;
         sector_index   <= ATF_RST_BYTE;
         track_low      <= ATF_RST_BYTE;
         track_high     <= ATF_RST_BYTE;
         drive_head     <= ATF_RST_BYTE;
         sector_wr_word <= ATF_RST_WORD;
         sector_wr_put  <= 1'b0;
      end else begin
         if (wr_precmp) precomp_cyl  <= wbyte;
         if (wr_scount) sector_count <= wbyte;
         if (wr_sindex) sector_index <= wbyte;
         if (wr_trk_lo) track_low    <= wbyte;
         if (wr_trk_hi) track_high   <= wbyte;
         if (wr_drvhd)  drive_head   <= wbyte;
         if (wr_data) begin
            sector_wr_word <= wdata_r;                    // RULE2
         end
         sector_wr_put <= wr_data;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // operation code decode

   wire [3:0] nib = wbyte[ATF_NIB_MSB:ATF_NIB_LSB];

   atf_op_e op_dec;
   always_comb begin
      case (nib)                                          // RULE8
         ATF_NIB_RESTORE: op_dec = ATF_OP_RESTORE;
         ATF_NIB_SEEK:    op_dec = ATF_OP_SEEK;
         ATF_NIB_READ:    op_dec = ATF_OP_READ;
         ATF_NIB_WRITE:   op_dec = ATF_OP_WRITE;
         ATF_NIB_FORMAT:  op_dec = ATF_OP_FORMAT;
         ATF_NIB_VERIFY:  op_dec = ATF_OP_VERIFY;
         ATF_NIB_DIAGSET: op_dec = wbyte[ATF_BIT_SELPAR] ? ATF_OP_SETPAR : ATF_OP_DIAG;
         default:         op_dec = ATF_OP_NONE;
      endcase
   end

   wire is_step  = (op_dec == ATF_OP_RESTORE) | (op_dec == ATF_OP_SEEK);
   wire is_rw    = (op_dec == ATF_OP_READ) | (op_dec == ATF_OP_WRITE);
   wire is_xfer  = is_rw | (op_dec == ATF_OP_FORMAT) | (op_dec == ATF_OP_VERIFY);
   wire is_retry = is_rw | (op_dec == ATF_OP_VERIFY);

   wire [3:0] rate_nxt  = is_step ? wbyte[ATF_RATE_MSB:0] : 4'h0;       // RULE4
   wire       dma_nxt   = is_xfer & wbyte[ATF_BIT_DMA];                 // RULE5
   wire       long_nxt  = is_rw & wbyte[ATF_BIT_LONG];                  // RULE6
   wire       retry_nxt = is_retry & wbyte[ATF_BIT_RETRY];              // RULE7

   // qualifiers stay until the next command write so the drive sees them
   // for the whole operation
   always_ff @(posedge clk) begin
      if (srst) begin
         cmd_start     <= 1'b0;
         cmd_op        <= ATF_OP_NONE;
         step_rate     <= 4'h0;
         use_dma       <= 1'b0;
         long_xfer     <= 1'b0;
         retry_inhibit <= 1'b0;
      end else begin
         cmd_start <= wr_opcode;
         if (wr_opcode) begin
            cmd_op        <= op_dec;                      // RULE8
            step_rate     <= rate_nxt;                    // RULE4
            use_dma       <= dma_nxt;                     // RULE5
            long_xfer     <= long_nxt;                    // RULE6
            retry_inhibit <= retry_nxt;                   // RULE7
         end
      end
   end

endmodule

//--- test/atf_task_file_props.sv
// Purpose: port checks for the task file block
// Assumes: write data held from one edge before the strobe
// Notes:   bound to every atf_task_file instance
`timescale 1ns/1ps
module atf_task_file_props
   import atf_pkg::*;
(
   input wire logic                  clk,
   input wire logic                  srst,
   input wire logic                  task_file_select_n,
   input wire logic [ATF_AW-1:0]     host_addr,
   input wire logic [ATF_DW-1:0]     host_data_i,
   input wire logic [ATF_DW-1:0]     host_data_o,
   input wire logic                  host_data_oe,
   input wire logic                  cmd_start,
   input wire atf_op_e               cmd_op,
   input wire logic [3:0]            step_rate,
   input wire logic                  use_dma,
   input wire logic                  long_xfer,
   input wire logic                  retry_inhibit
);
   default clocking @(posedge clk); endclocking
   default disable iff (srst);
   ////////////////////////////////////////////////////////////
   chk_idle_no_drive: assert property (task_file_select_n [*6] |-> !host_data_oe)
      else $error("data bus driven while deselected");
   chk_write_selected: assert property (cmd_start |-> !$past(task_file_select_n, 2))
      else $error("command taken while deselected");
   chk_byte_upper: assert property (host_data_oe && host_addr != ATF_OFF_DATA && $stable(host_addr)
      |-> host_data_o[15:8] == 8'h00) else $error("byte register upper half not zero");
   chk_rate_take: assert property (cmd_start && cmd_op inside {ATF_OP_RESTORE, ATF_OP_SEEK}
      |-> step_rate == $past(host_data_i[3:0], 2)) else $error("step rate mismatch");
   chk_rate_zero: assert property (cmd_start && !(cmd_op inside {ATF_OP_RESTORE, ATF_OP_SEEK})
      |-> step_rate == 4'h0) else $error("step rate on other command");
   chk_dma_take: assert property (cmd_start && cmd_op inside {ATF_OP_READ, ATF_OP_WRITE, ATF_OP_FORMAT,
      ATF_OP_VERIFY} |-> use_dma == $past(host_data_i[3], 2)) else $error("dma qualifier mismatch");
   chk_long_take: assert property (cmd_start && cmd_op inside {ATF_OP_READ, ATF_OP_WRITE}
      |-> long_xfer == $past(host_data_i[1], 2)) else $error("long qualifier mismatch");
   chk_retry_take: assert property (cmd_start && cmd_op inside {ATF_OP_READ, ATF_OP_WRITE, ATF_OP_VERIFY}
      |-> retry_inhibit == $past(host_data_i[0], 2)) else $error("retry qualifier mismatch");
   chk_op_read: assert property (cmd_start && $past(host_data_i[7:4], 2) == 4'h2
      |-> cmd_op == ATF_OP_READ) else $error("read command decoded wrongly");
   chk_diag_split: assert property (cmd_start && $past(host_data_i[7:4], 2) == 4'h9
      |-> cmd_op == ($past(host_data_i[0], 2) ? ATF_OP_SETPAR : ATF_OP_DIAG)) else $error("diag split wrong");
   chk_start_pulse: assert property (cmd_start |=> !cmd_start)
      else $error("command start longer than one cycle");
endmodule
bind atf_task_file atf_task_file_props u_props (.clk(clk), .srst(srst), .task_file_select_n(task_file_select_n),
   .host_addr(host_addr), .host_data_i(host_data_i), .host_data_o(host_data_o), .host_data_oe(host_data_oe),
   .cmd_start(cmd_start), .cmd_op(cmd_op), .step_rate(step_rate), .use_dma(use_dma), .long_xfer(long_xfer),
   .retry_inhibit(retry_inhibit));

//--- test/atf_host_model.sv
// Purpose: host side of the task file bus
// Assumes: strobes held six edges, idle four edges between accesses
// Notes:   released data lines flip so no stale value survives
`timescale 1ns/1ps
module atf_host_model (
   input  wire logic                         clk,
   output logic                              task_file_select_n,
   output logic                              host_rd_n,
   output logic                              host_wr_n,
   output logic      [atf_pkg::ATF_AW-1:0]   host_addr,
   output logic      [atf_pkg::ATF_DW-1:0]   host_data_i,
   input  wire logic [atf_pkg::ATF_DW-1:0]   host_data_o,
   input  wire logic                         host_data_oe
);
   initial begin
      task_file_select_n = 1'h1;
      host_rd_n = 1'h1;
      host_wr_n = 1'h1;
      host_addr = 3'h0;
      host_data_i = 16'h5a5a;
   end
   ////////////////////////////////////////////////////////////
   task automatic access(input logic wr, input logic sel_n, input logic [2:0] a, input logic [15:0] d,
                         output logic [15:0] q, output logic oe);
      @(posedge clk);
      task_file_select_n <= sel_n;
      host_addr <= a;
      host_data_i <= wr ? d : ~host_data_i;
      @(posedge clk);
      host_wr_n <= !wr;
      host_rd_n <= wr;
      repeat (5) @(posedge clk);
      @(negedge clk);
      q = host_data_o;
      oe = host_data_oe;
      @(posedge clk);
      host_wr_n <= 1'h1;
      host_rd_n <= 1'h1;
      // select outlives the strobe so the filter never sees a deselected tail
      repeat (4) @(posedge clk);
      task_file_select_n <= 1'h1;
      host_data_i <= ~host_data_i;
   endtask
endmodule

//--- test/tb_ata_task_file_registers.sv
// Purpose: self-checking bench for the task file block
// Assumes: host model paces every access
// Notes:   drive-side inputs random, commands cover every nibble
`timescale 1ns/1ps
module tb_ata_task_file_registers;
   import atf_pkg::*;
   logic clk, srst, sel_n, rd_n, wr_n, oe, cs, dma, lng, rty, o, take, put;
   logic [2:0] addr;
   logic [7:0] cond, flt, pc, sc, si, tl, th, dh, c;
   logic [7:0] b [1:6];
   logic [15:0] di, dout, rdw, wrw, q, w;
   logic [3:0] rate;
   atf_op_e op;
   integer seed = 32'h26684dd2;
   int fail_count = 0, n_tests = 0, cyc = 0;
   // pulse counters: one-cycle outputs are counted as they stand, then compared
   int n_cs = 0, n_put = 0, n_take = 0;
   atf_host_model host (.clk(clk), .task_file_select_n(sel_n), .host_rd_n(rd_n), .host_wr_n(wr_n),
      .host_addr(addr), .host_data_i(di), .host_data_o(dout), .host_data_oe(oe));
   atf_task_file dut (.clk(clk), .srst(srst), .task_file_select_n(sel_n), .host_rd_n(rd_n), .host_wr_n(wr_n),
      .host_addr(addr), .host_data_i(di), .host_data_o(dout), .host_data_oe(oe), .busy(cond[7]), .ready(cond[6]),
      .write_fault_flag(cond[5]), .seek_done_flag(cond[4]), .data_request(cond[3]), .corrected_data_flag(cond[2]),
      .index_pulse(cond[1]), .error_summary(cond[0]), .bad_block_flag(flt[7]), .crc_error_flag(flt[6]),
      .header_not_found_flag(flt[4]), .command_aborted_flag(flt[2]), .track_zero_missing_flag(flt[1]),
      .address_mark_missing_flag(flt[0]), .sector_rd_word(rdw), .sector_rd_take(take), .sector_wr_word(wrw),
      .sector_wr_put(put), .precomp_cyl(pc), .sector_count(sc), .sector_index(si), .track_low(tl), .track_high(th),
      .drive_head(dh), .cmd_start(cs), .cmd_op(op), .step_rate(rate), .use_dma(dma), .long_xfer(lng),
      .retry_inhibit(rty));
   ////////////////////////////////////////////////////////////
   task automatic chk(input logic [15:0] got, input logic [15:0] exp);
      n_tests++;
      if (got !== exp) begin
         fail_count++;
         $display("Error at %0t: saw %h expected %h", $time, got, exp);
      end
   endtask
   task test_done;
      if (fail_count == 0 && n_tests > 0) begin
         $display("== PASSED ==");
      end else begin
         $display("== FAILED ==");
      end
      $finish;
   endtask
   function automatic logic [15:0] exp_cmd(input logic [7:0] k);
      case (k[7:4])
         4'h1: exp_cmd = {ATF_OP_RESTORE, k[3:0], 3'h0};
         4'h7: exp_cmd = {ATF_OP_SEEK, k[3:0], 3'h0};
         4'h2: exp_cmd = {ATF_OP_READ, 4'h0, k[3], k[1:0]};
         4'h3: exp_cmd = {ATF_OP_WRITE, 4'h0, k[3], k[1:0]};
         4'h5: exp_cmd = {ATF_OP_FORMAT, 4'h0, k[3], 2'h0};
         4'h4: exp_cmd = {ATF_OP_VERIFY, 4'h0, k[3], 1'h0, k[0]};
         4'h9: exp_cmd = {k[0] ? ATF_OP_SETPAR : ATF_OP_DIAG, 7'h0};
         default: exp_cmd = {ATF_OP_NONE, 7'h0};
      endcase
   endfunction
   initial begin
      clk = 1'h0;
      forever #5 clk = ~clk;
   end
   // generous ceiling: about fifty accesses of twelve cycles each
   always @(posedge clk) begin
      cyc <= cyc + 1;
      if (cs === 1'b1) n_cs <= n_cs + 1;
      if (put === 1'b1) n_put <= n_put + 1;
      if (take === 1'b1) n_take <= n_take + 1;
      if (cyc == 3000) begin
         fail_count++;
         test_done;
      end
   end
   initial begin
      srst = 1'h1;
      cond = 8'h00;
      flt = 8'h00;
      rdw = 16'h0000;
      repeat (8) @(posedge clk);
      srst <= 1'h0;
      for (int a = 2; a < 7; a++) begin
         host.access(1'h0, 1'h0, 3'(a), 16'h0, q, o);
         chk(q, 16'h0000);
      end
      chk({7'h0, op}, {7'h0, ATF_OP_NONE});
      for (int a = 1; a < 7; a++) begin
         b[a] = 8'($random(seed));
         host.access(1'h1, 1'h0, 3'(a), {8'($random(seed)), b[a]}, q, o);
      end
      chk({pc, sc}, {b[1], b[2]});
      chk({si, tl}, {b[3], b[4]});
      chk({th, dh}, {b[5], b[6]});
      for (int a = 2; a < 7; a++) begin
         host.access(1'h0, 1'h0, 3'(a), 16'h0, q, o);
         chk(q, {8'h00, b[a]});
      end
      host.access(1'h1, 1'h1, 3'h2, {8'h00, ~b[2]}, q, o);
      chk({8'h00, sc}, {8'h00, b[2]});
      host.access(1'h0, 1'h1, 3'h7, 16'h0, q, o);
      chk({15'h0, o}, 16'h0000);
      // a command write while deselected must neither start nor change the operation
      host.access(1'h1, 1'h1, 3'h7, 16'h0021, q, o);
      chk({7'h0, op}, {7'h0, ATF_OP_NONE});
      chk(16'(n_cs), 16'h0000);
      for (int k = 1; k < 5; k++) begin
         @(posedge clk);
         cond <= 8'($random(seed));
         flt <= 8'($random(seed));
         rdw <= 16'($random(seed));
         w = 16'($random(seed));
         host.access(1'h0, 1'h0, 3'h7, 16'h0, q, o);
         chk(q, {8'h00, cond});
         chk({15'h0, o}, 16'h0001);
         host.access(1'h0, 1'h0, 3'h1, 16'h0, q, o);
         chk(q, {8'h00, flt & 8'hd7});
         host.access(1'h1, 1'h0, 3'h0, w, q, o);
         chk(wrw, w);
         chk(16'(n_put), 16'(k));
         host.access(1'h0, 1'h0, 3'h0, 16'h0, q, o);
         chk(q, rdw);
         chk(16'(n_take), 16'(k));
      end
      for (int i = 0; i < 18; i++) begin
         c = (i < 16) ? {4'(i), 4'($random(seed))} : {7'h48, 1'(i)};
         host.access(1'h1, 1'h0, 3'h7, {8'($random(seed)), c}, q, o);
         chk({op, rate, dma, lng, rty}, exp_cmd(c));
         chk(16'(n_cs), 16'(i + 1));
      end
      test_done;
   end
endmodule
